//--- verilog/mcl_channel_end.sv
`timescale 1ns/100ps
module mcl_channel_end (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // transceiver cable
  mcl_link_if.channel link,
  // transmit bit stream from the data link
  input wire logic tx_valid,
  input wire logic tx_bit,
  output logic tx_ready,
  output logic tx_active,
  // collision indication
  output logic collision_flag,
  // receive bit stream to the data link
  output logic rx_strobe,
  output logic rx_data,
  output logic rx_valid
);
  import mcl_pkg::*;

  // transmit buffer
  logic buf_valid;
  logic buf_bit;
  logic buf_pop;

  // encoder state
  mcl_state_t state;
  mcl_state_t next_state;
  logic half;
  logic next_half;
  logic [CNT_W-1:0] hcnt;
  logic [CNT_W-1:0] next_hcnt;
  logic [5:0] pidx;
  logic [5:0] next_pidx;
  logic cur;
  logic next_cur;
  logic line;
  logic next_line;
  logic half_end;
  logic cell_end;

  // collision state
  logic col_q;
  logic col_prev;
  logic [CNT_W-1:0] hold;
  logic [CNT_W-1:0] next_hold;
  logic next_collision;
  logic col_edge;

  // decoder state
  logic rx_q;
  logic rx_prev;
  logic [CNT_W-1:0] mcnt;
  logic [CNT_W-1:0] next_mcnt;
  logic locked;
  logic next_locked;
  logic next_rx_strobe;
  logic next_rx_data;
  logic next_rx_valid;
  logic rx_edge;

  mcl_skid #(
    .WIDTH(1)
  ) u_buf (
    .mclk(mclk),
    .arst_n(arst_n),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_bit),
    .out_valid(buf_valid),
    .out_ready(buf_pop),
    .out_data(buf_bit)
  );

  assign link.tx_pair = line;

  // encoder
  always_comb begin
    next_state = state;
    next_half = half;
    next_hcnt = hcnt;
    next_pidx = pidx;
    next_cur = cur;
    buf_pop = 1'b0;
    half_end = (hcnt == HALF_LAST);
    cell_end = half_end && half;
    if (state != MCL_IDLE) begin
      if (half_end) begin
        next_hcnt = CNT_ZERO;
        next_half = !half;
      end else begin
        next_hcnt = hcnt + CNT_ONE;
      end
    end
    case (state)
      MCL_IDLE: begin
        if (buf_valid) begin
          next_state = MCL_PRE;
          next_half = 1'b0;
          next_hcnt = CNT_ZERO;
          next_pidx = PRE_FIRST;
          next_cur = PREAMBLE[PRE_FIRST];
        end
      end
      MCL_PRE: begin
        if (cell_end) begin
          if (collision_flag || pidx == PRE_LAST) begin
            if (buf_valid) begin
              buf_pop = 1'b1;
              next_cur = buf_bit;
              next_state = MCL_DATA;
            end else begin
              next_state = MCL_IDLE;
            end
          end else begin
            next_pidx = pidx - 6'h01;
            next_cur = PREAMBLE[next_pidx];
          end
        end
      end
      MCL_DATA: begin
        if (cell_end) begin
          if (buf_valid) begin
            buf_pop = 1'b1;
            next_cur = buf_bit;
          end else begin
            next_state = MCL_IDLE;
          end
        end
      end
      default: begin
        next_state = MCL_IDLE;
      end
    endcase
    if (next_state == MCL_IDLE) begin
      next_line = IDLE_LEVEL;
    end else begin
      next_line = next_half ? next_cur : !next_cur;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= MCL_IDLE;
      half <= 1'b0;
      hcnt <= CNT_ZERO;
      pidx <= PRE_FIRST;
      cur <= 1'b0;
      line <= IDLE_LEVEL;
      tx_active <= 1'b0;
    end else begin
      state <= next_state;
      half <= next_half;
      hcnt <= next_hcnt;
      pidx <= next_pidx;
      cur <= next_cur;
      line <= next_line;
      tx_active <= (next_state != MCL_IDLE);
    end
  end

  // collision flag
  always_comb begin
    col_edge = col_q ^ col_prev;
    if (col_edge) begin
      next_hold = COL_HOLD_CYC;
    end else if (hold != CNT_ZERO) begin
      next_hold = hold - CNT_ONE;
    end else begin
      next_hold = CNT_ZERO;
    end
    next_collision = tx_active && (next_hold != CNT_ZERO);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      col_q <= 1'b0;
      col_prev <= 1'b0;
      hold <= CNT_ZERO;
      collision_flag <= 1'b0;
    end else begin
      col_q <= link.col_pair;
      col_prev <= col_q;
      hold <= next_hold;
      collision_flag <= next_collision;
    end
  end

  // decoder
  always_comb begin
    rx_edge = rx_q ^ rx_prev;
    next_mcnt = mcnt;
    next_locked = locked;
    next_rx_strobe = 1'b0;
    next_rx_data = rx_data;
    if (rx_edge && (!locked || mcnt >= MID_MIN_CYC)) begin
      next_locked = 1'b1;
      next_mcnt = CNT_ONE;
      next_rx_strobe = 1'b1;
      next_rx_data = rx_q;
    end else begin
      if (mcnt < LOCK_LOSS_CYC) begin
        next_mcnt = mcnt + CNT_ONE;
      end
      if (!rx_edge && mcnt >= LOCK_LOSS_CYC) begin
        next_locked = 1'b0;
      end
    end
    // recovered stream is usable from the first locked cell while no collision is flagged
    next_rx_valid = next_locked && !next_collision;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_q <= IDLE_LEVEL;
      rx_prev <= IDLE_LEVEL;
      mcnt <= LOCK_LOSS_CYC;
      locked <= 1'b0;
      rx_strobe <= 1'b0;
      rx_data <= 1'b0;
      rx_valid <= 1'b0;
    end else begin
      rx_q <= link.rx_pair;
      rx_prev <= rx_q;
      mcnt <= next_mcnt;
      locked <= next_locked;
      rx_strobe <= next_rx_strobe;
      rx_data <= next_rx_data;
      rx_valid <= next_rx_valid;
    end
  end
endmodule

//--- verilog/mcl_pkg.sv
package mcl_pkg;
  // clock and line timing
  localparam int CLK_NS = 40;
  localparam int BIT_NS = 100;
  localparam int HALF_NS = BIT_NS / 2;
  localparam int HALF_CYC_I = (HALF_NS / CLK_NS) < 1 ? 1 : (HALF_NS / CLK_NS);
  localparam int CELL_CYC_I = 2 * HALF_CYC_I;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] HALF_CYC = CNT_W'(HALF_CYC_I);
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYC_I - 1);
  // decoder window: a mid-cell edge is one at least three quarters of a cell after the last
  localparam logic [CNT_W-1:0] MID_MIN_CYC = CNT_W'((3 * CELL_CYC_I + 3) / 4);
  localparam logic [CNT_W-1:0] LOCK_LOSS_CYC = CNT_W'(CELL_CYC_I + HALF_CYC_I);
  // collision flag hold time after the last presence edge
  localparam int COL_OFF_NS = 160;
  localparam int COL_PIPE_CYC = 2;
  localparam int COL_HOLD_I = (COL_OFF_NS / CLK_NS) - COL_PIPE_CYC;
  localparam logic [CNT_W-1:0] COL_HOLD_CYC = CNT_W'(COL_HOLD_I < 1 ? 1 : COL_HOLD_I);
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  // preamble, sent msb first
  localparam int PRE_BITS = 64;
  localparam logic [PRE_BITS-1:0] PREAMBLE = 64'haaaa_aaaa_aaaa_aaab;
  localparam logic [5:0] PRE_FIRST = 6'h3f;
  localparam logic [5:0] PRE_LAST = 6'h00;
  localparam logic IDLE_LEVEL = 1'b0;
  // encoder states
  typedef enum logic [1:0] {
    MCL_IDLE = 2'b00,
    MCL_PRE = 2'b01,
    MCL_DATA = 2'b10
  } mcl_state_t;
endpackage

//--- verilog/mcl_link_if.sv
`timescale 1ns/100ps
interface mcl_link_if;
  logic tx_pair;
  logic rx_pair;
  logic col_pair;
  modport channel (
    output tx_pair,
    input rx_pair,
    input col_pair
  );
  modport xcvr (
    input tx_pair,
    output rx_pair,
    output col_pair
  );
endinterface

//--- verilog/mcl_skid.sv
`timescale 1ns/100ps
module mcl_skid #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] slot0;
  logic [WIDTH-1:0] slot1;
  logic [1:0] fill;
  logic [WIDTH-1:0] next_slot0;
  logic [WIDTH-1:0] next_slot1;
  logic [1:0] next_fill;
  logic push;
  logic pop;
  logic next_in_ready;

  assign out_valid = (fill != 2'h0);
  assign out_data = slot0;

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_slot0 = slot0;
    next_slot1 = slot1;
    next_fill = fill;
    case ({push, pop})
      2'b10: begin
        if (fill == 2'h0) begin
          next_slot0 = in_data;
        end else begin
          next_slot1 = in_data;
        end
        next_fill = fill + 2'h1;
      end
      2'b01: begin
        next_slot0 = slot1;
        next_fill = fill - 2'h1;
      end
      2'b11: begin
        if (fill == 2'h1) begin
          next_slot0 = in_data;
        end else begin
          next_slot0 = slot1;
          next_slot1 = in_data;
        end
      end
      default: begin
      end
    endcase
    // ready is registered so the fill-side port comes straight from a flop
    next_in_ready = (next_fill != 2'h2);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      slot0 <= '0;
      slot1 <= '0;
      fill <= 2'h0;
      in_ready <= 1'b1;
    end else begin
      slot0 <= next_slot0;
      slot1 <= next_slot1;
      fill <= next_fill;
      in_ready <= next_in_ready;
    end
  end
endmodule

//--- verilog/mcl_xcvr_end.sv
`timescale 1ns/100ps
module mcl_xcvr_end (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // cable side
  mcl_link_if.xcvr link,
  // medium side
  output logic medium_tx,
  input wire logic medium_rx,
  input wire logic medium_collide
);
  import mcl_pkg::*;

  logic next_medium_tx;
  logic next_rx_pair;
  logic next_col_pair;
  logic rx_q;
  logic col_q;

  assign link.rx_pair = rx_q;
  assign link.col_pair = col_q;

  always_comb begin
    // forwarded with no cells swallowed and no inversion
    next_medium_tx = link.tx_pair;
    // incoming cells passed on unchanged, none lost
    next_rx_pair = medium_rx;
    // presence waveform starts on the first clock of a collision
    next_col_pair = medium_collide ? !col_q : 1'b0;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      medium_tx <= IDLE_LEVEL;
      rx_q <= IDLE_LEVEL;
      col_q <= 1'b0;
    end else begin
      medium_tx <= next_medium_tx;
      rx_q <= next_rx_pair;
      col_q <= next_col_pair;
    end
  end
endmodule

//--- bench/mcl_link_properties.sv
`timescale 1ns/100ps
module mcl_link_properties (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // cable
  input wire logic tx_pair,
  input wire logic rx_pair,
  input wire logic col_pair,
  // channel user side
  input wire logic tx_active,
  input wire logic collision_flag,
  input wire logic rx_strobe,
  input wire logic rx_data,
  input wire logic rx_valid
);
  import mcl_pkg::*;
  logic half;
  logic next_half;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  // phase within the current transmit cell
  always_comb next_half = tx_active & ~half;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) half <= 1'b0;
    else half <= next_half;
  end
  sequence pre_head;
    !tx_pair ##1 tx_pair [*2] ##1 !tx_pair [*2] ##1 tx_pair;
  endsequence
  sequence rx_first;
    !rx_valid && $stable(rx_pair) ##1 !rx_valid && $changed(rx_pair);
  endsequence
  chk_pre_head: assert property ($rose(tx_active) |-> pre_head)
    else $error("preamble start wrong");
  chk_mid_edge: assert property (tx_active && !half |=> $changed(tx_pair))
    else $error("no mid-cell transition");
  chk_idle_level: assert property (!tx_active [*2] |-> tx_pair == IDLE_LEVEL)
    else $error("idle line moved");
  chk_flag_rise: assert property (
    tx_active && $changed(col_pair) |-> ##[1:5] (collision_flag || !tx_active))
    else $error("collision flag late");
  chk_flag_idle: assert property (!tx_active [*2] |-> !collision_flag)
    else $error("collision flag while idle");
  chk_flag_fall: assert property ($stable(col_pair) [*5] |-> !collision_flag)
    else $error("collision flag held");
  chk_rx_lock: assert property (
    rx_first |-> ##2 (rx_strobe && rx_data == $past(rx_pair, 2)))
    else $error("decoder lock late");
  chk_strobe_pulse: assert property (rx_strobe |=> !rx_strobe)
    else $error("strobe too long");
  chk_strobe_data: assert property (rx_strobe |-> rx_data == $past(rx_pair, 2))
    else $error("decoded bit wrong");
  chk_col_wave: assert property (col_pair |=> !col_pair)
    else $error("presence waveform stuck high");
endmodule

//--- bench/manchester_channel_logic_test.sv
`timescale 1ns/100ps
module manchester_channel_logic_test;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic tx_valid = 1'b0;
  logic tx_bit = 1'b0;
  logic medium_rx = 1'b0;
  logic medium_collide = 1'b0;
  logic rx_en = 1'b1;
  logic flag_seen = 1'b0;
  logic valid_seen = 1'b0;
  logic tx_ready, tx_active, collision_flag, rx_strobe, rx_data, rx_valid, medium_tx;
  logic rxq[$];
  int bad_count = 0;
  int n_compared = 0;
  int act = 0;
  mcl_link_if mcl_link_if_i ();
  mcl_channel_end mcl_channel_end_i (.mclk(mclk), .arst_n(arst_n), .link(mcl_link_if_i),
    .tx_valid(tx_valid), .tx_bit(tx_bit), .tx_ready(tx_ready), .tx_active(tx_active),
    .collision_flag(collision_flag), .rx_strobe(rx_strobe), .rx_data(rx_data),
    .rx_valid(rx_valid));
  mcl_xcvr_end mcl_xcvr_end_i (.mclk(mclk), .arst_n(arst_n), .link(mcl_link_if_i),
    .medium_tx(medium_tx), .medium_rx(medium_rx), .medium_collide(medium_collide));
  mcl_link_properties mcl_link_properties_i (.mclk(mclk), .arst_n(arst_n),
    .tx_pair(mcl_link_if_i.tx_pair), .rx_pair(mcl_link_if_i.rx_pair),
    .col_pair(mcl_link_if_i.col_pair), .tx_active(tx_active),
    .collision_flag(collision_flag), .rx_strobe(rx_strobe), .rx_data(rx_data),
    .rx_valid(rx_valid));
  always #20 mclk = ~mclk;
  // medium loops the sent frame back to the receiver
  always @(posedge mclk) begin
    medium_rx <= rx_en & medium_tx;
    if (rx_strobe === 1'b1) rxq.push_back(rx_data);
    if (rx_valid === 1'b1) valid_seen <= 1'b1;
    if (collision_flag === 1'b1) flag_seen <= 1'b1;
    if (tx_active === 1'b1) act <= act + 1;
  end
  task automatic check(input string what, input logic [15:0] expv, input logic [15:0] got);
    n_compared++;
    if (got !== expv) begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", what, expv, got);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  function automatic logic gen_bit(input int mode);
    return (mode == 0) ? logic'($urandom_range(1)) : (mode == 2);
  endfunction
  task automatic do_reset;
    arst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    check("reset outputs", 16'h8, {tx_ready, tx_active, collision_flag, rx_valid});
    arst_n <= 1'b1;
    @(posedge mclk);
  endtask
  task automatic send_frame(input int n, input int mode, input bit coll);
    logic exp[$];
    int i;
    int k;
    int cyc;
    int skip;
    for (i = 0; i < n; i++) exp.push_back(gen_bit(mode));
    skip = $urandom_range(12, 4);
    rxq.delete();
    rx_en <= 1'b0;
    act <= 0;
    flag_seen <= 1'b0;
    valid_seen <= 1'b0;
    @(posedge mclk);
    i = 0;
    cyc = 0;
    tx_valid <= 1'b1;
    tx_bit <= exp[0];
    while ((i < n || cyc < 4 || tx_active !== 1'b0) && cyc < 600) begin
      @(posedge mclk);
      cyc++;
      if (i < n && tx_ready === 1'b1) i++;
      tx_valid <= (i < n);
      tx_bit <= exp[(i < n) ? i : 0];
      // receiver joins late: leading cells swallowed, first edge may be a false mid
      if (!coll && cyc == skip) rx_en <= 1'b1;
      if (coll) medium_collide <= (cyc >= 12 && cyc < 24);
    end
    repeat (6) @(posedge mclk);
    check("frame done", 1, cyc < 600);
    if (coll) begin
      check("flag raised", 1, flag_seen);
      check("preamble cut", 1, act < 2 * (64 + n));
    end else begin
      check("frame length", 1, act >= 2 * (64 + n));
      check("bits decoded", 1, rxq.size() >= n + 56);
      check("rx valid", 1, valid_seen);
      for (k = 0; k < n + 2 && rxq.size() >= n + 2; k++)
        check("rx bit", (k < 2) ? 1'b1 : exp[k - 2], rxq[rxq.size() - n - 2 + k]);
    end
  endtask
  initial begin
    void'($urandom(31606));
    do_reset();
    send_frame(1, 2, 0);
    send_frame(16, 1, 0);
    send_frame(16, 2, 0);
    for (int f = 0; f < 4; f++) send_frame(8 + $urandom_range(24), 0, 0);
    send_frame(20, 0, 1);
    flag_seen <= 1'b0;
    medium_collide <= 1'b1;
    repeat (10) @(posedge mclk);
    medium_collide <= 1'b0;
    repeat (8) @(posedge mclk);
    check("idle flag", 0, flag_seen);
    do_reset();
    send_frame(12, 0, 0);
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    end_of_test();
  end
endmodule
